// [src/ams_map.svh]
`ifndef AMS_MAP_SVH
`define AMS_MAP_SVH

// ==========================================================================
// Bus widths
`define AMS_CODE_W 3
`define AMS_AD_W 32
`define AMS_CBE_W 4

// ==========================================================================
// Arbiter status codes, meaningful only under grant
`define AMS_CODE_LP_READ 3'h0
`define AMS_CODE_HP_READ 3'h1
`define AMS_CODE_LP_WRITE 3'h2
`define AMS_CODE_HP_WRITE 3'h3
`define AMS_CODE_RSVD_4 3'h4
`define AMS_CODE_RSVD_5 3'h5
`define AMS_CODE_RSVD_6 3'h6
`define AMS_CODE_START 3'h7

// ==========================================================================
// Reset levels of the active-low outputs and the address/data lines
`define AMS_RST_LEVEL_N 1'b1
`define AMS_RST_AD 32'h0000_0000
`define AMS_RST_CBE 4'hf

`endif

// [src/ams_pkg.sv]
`default_nettype none

package ams_pkg;

	// ======================================================================
	// Sequencer states
	typedef enum logic [3:0] {
		ST_IDLE,
		ST_PIPE,
		ST_PIPE_END,
		ST_FRAME,
		ST_READ,
		ST_RD_END,
		ST_WR_LOAD,
		ST_WRITE,
		ST_WR_END
	} ams_state_e;

	typedef logic [31:0] ams_word_t;

endpackage : ams_pkg

`default_nettype wire

// [src/ams_status_decode.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"

module ams_status_decode (
	// Arbiter inputs
	input wire logic bus_grant_n,
	input wire logic [`AMS_CODE_W-1:0] arbiter_status_code,
	// Decoded events
	output logic st_lp_read,
	output logic st_hp_read,
	output logic st_lp_write,
	output logic st_hp_write,
	output logic st_start,
	output logic st_reserved
);

	function automatic logic code_is(input logic [`AMS_CODE_W-1:0] c,
		input logic [`AMS_CODE_W-1:0] ref_code, input logic grant_n);
		code_is = !grant_n && (c == ref_code);
	endfunction : code_is

	// Without grant every output stays low, so the code is ignored
	assign st_lp_read = code_is(arbiter_status_code, `AMS_CODE_LP_READ, bus_grant_n);
	assign st_hp_read = code_is(arbiter_status_code, `AMS_CODE_HP_READ, bus_grant_n);
	assign st_lp_write = code_is(arbiter_status_code, `AMS_CODE_LP_WRITE, bus_grant_n);
	assign st_hp_write = code_is(arbiter_status_code, `AMS_CODE_HP_WRITE, bus_grant_n);
	assign st_start = code_is(arbiter_status_code, `AMS_CODE_START, bus_grant_n);
	// Reserved codes decode to nothing the sequencer acts on
	assign st_reserved = code_is(arbiter_status_code, `AMS_CODE_RSVD_4, bus_grant_n)
		| code_is(arbiter_status_code, `AMS_CODE_RSVD_5, bus_grant_n)
		| code_is(arbiter_status_code, `AMS_CODE_RSVD_6, bus_grant_n);

endmodule : ams_status_decode
`default_nettype wire

// [src/ams_sideband_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
`include "ams_map.svh"

// Summary of operation
// - Status code used only under grant
// - Code 000 returns low-priority read data
// - Code 001 returns high-priority read data
// - Code 010 device supplies low-priority writes
// - Code 011 device supplies high-priority writes
// - Code 111 grants start of transaction
// - Start allows pipelined requests or frame
// - Device shows low-priority read buffer space
// - Pipelined request only while current master
// - One request queued per asserted edge
// - No request queued while deasserted
// - Pipelined request is sustained tri-state
// - Address/data strobes have no function
// - Command lines carry request commands
// - Write data without wait states
// - No wait in first read block
module ams_sideband_ctrl (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset,
	// Arbiter status
	input wire logic bus_grant_n,
	input wire logic [`AMS_CODE_W-1:0] arbiter_status_code,
	// Sideband outputs
	output logic read_buffer_full_n,
	output logic pipelined_request_n,
	output logic pipelined_request_oe,
	// Shared address/data and command lines
	input wire logic [`AMS_AD_W-1:0] muxed_addr_data_in,
	output logic [`AMS_AD_W-1:0] muxed_addr_data_out,
	output logic muxed_addr_data_oe,
	output logic [`AMS_CBE_W-1:0] command_byte_enable_n_out,
	output logic command_byte_enable_n_oe,
	// Transaction control
	output logic cycle_frame_n_out,
	output logic cycle_frame_n_oe,
	output logic initiator_ready_n_out,
	output logic initiator_ready_oe,
	input wire logic target_ready_n,
	// Unused strobe pins
	input wire logic addr_data_strobe_0_in,
	output logic addr_data_strobe_0_out,
	output logic addr_data_strobe_0_oe,
	input wire logic addr_data_strobe_1_in,
	output logic addr_data_strobe_1_out,
	output logic addr_data_strobe_1_oe,
	// Request queue from the user
	input wire logic req_valid,
	output logic req_ready,
	input wire logic [`AMS_AD_W-1:0] req_addr,
	input wire logic [`AMS_CBE_W-1:0] req_cmd,
	// Ordinary transaction start
	input wire logic pci_start_req,
	output logic pci_start_ack,
	// Read return
	input wire logic rd_space_lp,
	output logic rd_valid,
	output logic [`AMS_AD_W-1:0] rd_data,
	output logic rd_high_prio,
	// Write supply
	input wire logic wr_valid,
	output logic wr_ready,
	input wire logic [`AMS_AD_W-1:0] wr_data,
	input wire logic [`AMS_CBE_W-1:0] wr_byte_en_n,
	input wire logic wr_last,
	output logic wr_high_prio
);

	// ======================================================================
	// Status decode
	logic st_lp_read;
	logic st_hp_read;
	logic st_lp_write;
	logic st_hp_write;
	logic st_start;
	logic st_reserved;

	ams_status_decode u_decode (
		.bus_grant_n(bus_grant_n),
		.arbiter_status_code(arbiter_status_code),
		.st_lp_read(st_lp_read),
		.st_hp_read(st_hp_read),
		.st_lp_write(st_lp_write),
		.st_hp_write(st_hp_write),
		.st_start(st_start),
		.st_reserved(st_reserved)
	);

	// ======================================================================
	// Registers
	ams_pkg::ams_state_e state_reg;
	ams_pkg::ams_state_e state_next;
	logic pipe_n_reg;
	logic pipe_oe_reg;
	logic [`AMS_AD_W-1:0] ad_reg;
	logic ad_oe_reg;
	logic [`AMS_CBE_W-1:0] cbe_reg;
	logic cbe_oe_reg;
	logic frame_n_reg;
	logic frame_oe_reg;
	logic irdy_n_reg;
	logic irdy_oe_reg;
	logic rbf_n_reg;
	logic rd_valid_reg;
	logic [`AMS_AD_W-1:0] rd_data_reg;
	logic rd_hp_reg;
	logic wr_hp_reg;
	logic wr_last_reg;

	// ======================================================================
	// Event decode
	wire in_idle = (state_reg == ams_pkg::ST_IDLE);
	wire in_pipe = (state_reg == ams_pkg::ST_PIPE);
	wire in_read = (state_reg == ams_pkg::ST_READ);
	wire in_wr_load = (state_reg == ams_pkg::ST_WR_LOAD);
	wire in_write = (state_reg == ams_pkg::ST_WRITE);
	wire start_pipe = in_idle && st_start && req_valid;
	// frame path used when no request waits
	wire start_frame = in_idle && st_start && !req_valid && pci_start_req;
	// queue only as master, after start
	wire pipe_take = start_pipe || (in_pipe && req_valid && !bus_grant_n);
	wire rd_start_lp = in_idle && st_lp_read;
	wire rd_start_hp = in_idle && st_hp_read;
	wire rd_start = rd_start_lp || rd_start_hp;
	wire wr_start_lp = in_idle && st_lp_write;
	wire wr_start_hp = in_idle && st_hp_write;
	wire wr_start = wr_start_lp || wr_start_hp;
	wire rd_beat = in_read && !target_ready_n;
	wire wr_beat = in_write && !target_ready_n;
	wire wr_done = wr_beat && wr_last_reg;
	wire wr_first = in_wr_load && wr_valid;
	// Once ready is raised the next word is fetched on each beat but the last
	wire wr_load = wr_first || (wr_beat && !wr_last_reg);
	wire ad_drive = pipe_take || wr_load || (in_write && !wr_done);
	// ready held through the whole write
	wire irdy_low = wr_first || (in_write && !wr_done);
	// ready with the first read block
	wire rd_ready_low = rd_start || (in_read && !bus_grant_n);

	// ======================================================================
	// Sequencer
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			// reserved or ungranted codes keep idle
			ams_pkg::ST_IDLE: begin
				if (start_pipe)
					state_next = ams_pkg::ST_PIPE;
				else if (start_frame)
					state_next = ams_pkg::ST_FRAME;
				else if (rd_start)
					state_next = ams_pkg::ST_READ;
				else if (wr_start)
					state_next = ams_pkg::ST_WR_LOAD;
			end
			ams_pkg::ST_PIPE: begin
				if (!pipe_take)
					state_next = ams_pkg::ST_PIPE_END;
			end
			// one parked cycle, then back to idle
			ams_pkg::ST_PIPE_END: state_next = ams_pkg::ST_IDLE;
			ams_pkg::ST_FRAME: state_next = ams_pkg::ST_IDLE;
			ams_pkg::ST_READ: begin
				if (bus_grant_n)
					state_next = ams_pkg::ST_RD_END;
			end
			ams_pkg::ST_RD_END: state_next = ams_pkg::ST_IDLE;
			ams_pkg::ST_WR_LOAD: begin
				if (wr_valid)
					state_next = ams_pkg::ST_WRITE;
			end
			ams_pkg::ST_WRITE: begin
				if (wr_done)
					state_next = ams_pkg::ST_WR_END;
			end
			ams_pkg::ST_WR_END: state_next = ams_pkg::ST_IDLE;
			default: state_next = ams_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (reset)
			state_reg <= ams_pkg::ST_IDLE;
		else
			state_reg <= state_next;
	end

	// ======================================================================
	// Pipelined request pin
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			pipe_n_reg <= `AMS_RST_LEVEL_N;
			pipe_oe_reg <= 1'b0;
		end else begin
			// one queued request per low edge
			pipe_n_reg <= !pipe_take;
			// driven high one cycle before release
			pipe_oe_reg <= pipe_take || in_pipe;
		end
	end

	// ======================================================================
	// Address/data and command lines
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			ad_reg <= `AMS_RST_AD;
			cbe_reg <= `AMS_RST_CBE;
			ad_oe_reg <= 1'b0;
			cbe_oe_reg <= 1'b0;
		end else begin
			ad_oe_reg <= ad_drive;
			cbe_oe_reg <= ad_drive;
			// request command on the command lines
			if (pipe_take) begin
				ad_reg <= req_addr;
				cbe_reg <= req_cmd;
			end else if (wr_load) begin
				ad_reg <= wr_data;
				cbe_reg <= wr_byte_en_n;
			end
		end
	end

	// ======================================================================
	// Frame and initiator ready
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			frame_n_reg <= `AMS_RST_LEVEL_N;
			frame_oe_reg <= 1'b0;
			irdy_n_reg <= `AMS_RST_LEVEL_N;
			irdy_oe_reg <= 1'b0;
		end else begin
			frame_n_reg <= !start_frame;
			frame_oe_reg <= start_frame || (state_reg == ams_pkg::ST_FRAME);
			irdy_n_reg <= !(irdy_low || rd_ready_low);
			irdy_oe_reg <= irdy_low || rd_ready_low || in_read || in_write;
		end
	end

	// ======================================================================
	// Read return and buffer space
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			rbf_n_reg <= `AMS_RST_LEVEL_N;
			rd_valid_reg <= 1'b0;
			rd_data_reg <= `AMS_RST_AD;
			rd_hp_reg <= 1'b0;
		end else begin
			// asserted low when no low-priority space
			rbf_n_reg <= rd_space_lp;
			rd_valid_reg <= rd_beat;
			if (rd_beat)
				rd_data_reg <= muxed_addr_data_in;
			if (rd_start)
				rd_hp_reg <= rd_start_hp;
		end
	end

	// ======================================================================
	// Write bookkeeping
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			wr_hp_reg <= 1'b0;
			wr_last_reg <= 1'b0;
		end else begin
			if (wr_start)
				wr_hp_reg <= wr_start_hp;
			if (wr_load)
				wr_last_reg <= wr_last;
		end
	end

	// ======================================================================
	// Outputs
	assign read_buffer_full_n = rbf_n_reg;
	assign pipelined_request_n = pipe_n_reg;
	assign pipelined_request_oe = pipe_oe_reg;
	assign muxed_addr_data_out = ad_reg;
	assign muxed_addr_data_oe = ad_oe_reg;
	assign command_byte_enable_n_out = cbe_reg;
	assign command_byte_enable_n_oe = cbe_oe_reg;
	assign cycle_frame_n_out = frame_n_reg;
	assign cycle_frame_n_oe = frame_oe_reg;
	assign initiator_ready_n_out = irdy_n_reg;
	assign initiator_ready_oe = irdy_oe_reg;
	assign req_ready = pipe_take;
	assign pci_start_ack = start_frame;
	assign rd_valid = rd_valid_reg;
	assign rd_data = rd_data_reg;
	assign rd_high_prio = rd_hp_reg;
	assign wr_ready = wr_load;
	assign wr_high_prio = wr_hp_reg;
	// strobes never driven; inputs deliberately left unread
	assign addr_data_strobe_0_out = 1'b0;
	assign addr_data_strobe_0_oe = 1'b0;
	assign addr_data_strobe_1_out = 1'b0;
	assign addr_data_strobe_1_oe = 1'b0;

	// ======================================================================
	// Assertions
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	sequence seq_pipe_park;
		pipelined_request_n && pipelined_request_oe ##1 !pipelined_request_oe;
	endsequence

	sequence seq_wr_open;
		wr_start_lp ##1 (in_wr_load && wr_valid);
	endsequence

	AST_NO_ACTION: assert property ((in_idle && (bus_grant_n || st_reserved))
		|=> state_reg == ams_pkg::ST_IDLE)
		else $error("Idle left on ignored or reserved status code");
	AST_RD_ACCEPT: assert property (rd_beat
		|=> rd_valid && rd_data == $past(muxed_addr_data_in))
		else $error("Read beat not delivered");
	AST_RD_PRIO: assert property (rd_start
		|=> in_read && rd_high_prio == $past(st_hp_read))
		else $error("Read priority not recorded");
	AST_WR_SUPPLY: assert property (wr_start
		|=> in_wr_load && wr_high_prio == $past(st_hp_write))
		else $error("Write supply not opened");
	AST_WR_LOW: assert property (seq_wr_open
		|=> !initiator_ready_n_out && muxed_addr_data_oe && !wr_high_prio)
		else $error("Low-priority write not started");
	AST_FRAME_START: assert property (start_frame
		|=> !cycle_frame_n_out && cycle_frame_n_oe ##1 cycle_frame_n_out)
		else $error("Frame not driven for one cycle");
	AST_RBF: assert property (##1 read_buffer_full_n == $past(rd_space_lp))
		else $error("Buffer full flag stale");
	AST_PIPE_MASTER: assert property ($fell(pipelined_request_n)
		|-> $past(st_start))
		else $error("Pipelined request without start permission");
	AST_PIPE_ONE: assert property (pipe_take
		|=> !pipelined_request_n && muxed_addr_data_out == $past(req_addr) && muxed_addr_data_oe)
		else $error("Request not placed on bus");
	AST_PIPE_NONE: assert property (!pipe_take |=> pipelined_request_n)
		else $error("Pipelined request without a taken request");
	AST_PIPE_TRI: assert property (!pipelined_request_n |-> pipelined_request_oe)
		else $error("Pipelined request asserted undriven");
	AST_STROBE: assert property (!addr_data_strobe_0_oe && !addr_data_strobe_1_oe)
		else $error("Strobe pin driven");
	AST_CBE_CMD: assert property (pipe_take
		|=> command_byte_enable_n_out == $past(req_cmd))
		else $error("Request command missing");
	AST_WR_NOWAIT: assert property ((in_write && !wr_done)
		|=> !initiator_ready_n_out)
		else $error("Wait state inserted in write");
	AST_RD_NOWAIT: assert property (rd_start
		|=> !initiator_ready_n_out && initiator_ready_oe)
		else $error("Initiator not ready for first read block");
	AST_PIPE_PARK: assert property ((in_pipe && !pipe_take)
		|=> seq_pipe_park)
		else $error("Pipelined request not parked before release");

endmodule : ams_sideband_ctrl
`default_nettype wire

// [dv/ams_arbiter_model.sv]
`timescale 1ns/1ps
`default_nettype none

module ams_arbiter_model (
	// Clock
	input wire logic clk_sys,
	// Arbiter and target drive
	output logic bus_grant_n,
	output logic [2:0] arbiter_status_code,
	output logic target_ready_n,
	output logic [31:0] ad_drv,
	// Device pins seen
	input wire logic read_buffer_full_n,
	input wire logic pipelined_request_n,
	input wire logic pipelined_request_oe,
	input wire logic initiator_ready_n,
	input wire logic [31:0] ad_dev,
	input wire logic [3:0] cbe_dev
);
	logic [2:0] code_sel = 3'h0;
	logic [2:0] idle_pat = 3'h0;
	logic wr_on = 1'b0;
	logic [35:0] queued[$];
	logic [35:0] written[$];

	// ========
	// Status lines
	// Code keeps moving while ungranted, so a stale value is never seen
	// arbiter drives code
	assign arbiter_status_code = bus_grant_n ? idle_pat : code_sel;

	initial begin
		bus_grant_n = 1'b1;
		target_ready_n = 1'b1;
		ad_drv = 32'h5a5a_5a5a;
	end

	always @(negedge clk_sys) idle_pat <= idle_pat + 3'h1;

	task grant(input logic [2:0] c);
		@(negedge clk_sys);
		code_sel = c;
		bus_grant_n = 1'b0;
	endtask : grant

	// Released data lines flip rather than hold
	task drop_grant();
		@(negedge clk_sys);
		bus_grant_n = 1'b1;
		target_ready_n = 1'b1;
		wr_on = 1'b0;
		ad_drv = ~ad_drv;
	endtask : drop_grant

	// ========
	// Transfers
	// return reads, low-priority ones not when full
	task read_back(input logic [2:0] c, input int n, input logic [31:0] base);
		if (c == 3'h0 && read_buffer_full_n !== 1'b1) return;
		grant(c);
		for (int i = 0; i < n; i++) begin
			@(negedge clk_sys);
			target_ready_n = 1'b0;
			ad_drv = base + 32'(i);
		end
		drop_grant();
	endtask : read_back

	task write_take(input logic [2:0] c, input int n);
		int k;
		grant(c);
		wr_on = 1'b1;
		k = 0;
		while (initiator_ready_n !== 1'b0 && k < 16) begin
			@(negedge clk_sys);
			k++;
		end
		target_ready_n = 1'b0;
		repeat (n - 1) @(negedge clk_sys);
		drop_grant();
	endtask : write_take

	always @(posedge clk_sys) begin
		if (pipelined_request_oe === 1'b1 && pipelined_request_n === 1'b0)
			queued.push_back({cbe_dev, ad_dev});
		if (wr_on && initiator_ready_n === 1'b0 && target_ready_n === 1'b0)
			written.push_back({cbe_dev, ad_dev});
	end
endmodule : ams_arbiter_model

`default_nettype wire

// [dv/ams_sideband_ctrl_bench.sv]
`timescale 1ns/1ps
`default_nettype none

module ams_sideband_ctrl_bench;
	// ========
	// Pins
	logic clk_sys, reset = 1'b1;
	logic bus_grant_n, target_ready_n, read_buffer_full_n;
	logic [2:0] arbiter_status_code;
	logic pipelined_request_n, pipelined_request_oe, muxed_addr_data_oe;
	logic [31:0] muxed_addr_data_in, muxed_addr_data_out, ad_drv, rd_data;
	logic [3:0] command_byte_enable_n_out;
	logic command_byte_enable_n_oe, cycle_frame_n_out, cycle_frame_n_oe;
	logic initiator_ready_n_out, initiator_ready_oe, req_ready, pci_start_ack;
	logic addr_data_strobe_0_in, addr_data_strobe_0_out, addr_data_strobe_0_oe;
	logic addr_data_strobe_1_in, addr_data_strobe_1_out, addr_data_strobe_1_oe;
	logic req_valid = 1'b0, pci_start_req = 1'b0, rd_space_lp = 1'b1;
	logic wr_valid = 1'b0, wr_last = 1'b0;
	logic rd_valid, rd_high_prio, wr_ready, wr_high_prio;
	logic [31:0] req_addr = 32'h0000_0000, wr_data = 32'h0000_0000;
	logic [3:0] req_cmd = 4'h0, wr_byte_en_n = 4'hf;
	logic [32:0] rd_log[$];
	int fails = 0, n_compared = 0;

	// Nobody else drives the strobe lines
	assign addr_data_strobe_0_in = addr_data_strobe_0_oe ? addr_data_strobe_0_out : 1'b0;
	assign addr_data_strobe_1_in = addr_data_strobe_1_oe ? addr_data_strobe_1_out : 1'b0;
	assign muxed_addr_data_in = muxed_addr_data_oe ? muxed_addr_data_out : ad_drv;

	ams_sideband_ctrl i_ams_sideband_ctrl (
		.clk_sys, .reset, .bus_grant_n, .arbiter_status_code, .read_buffer_full_n,
		.pipelined_request_n, .pipelined_request_oe, .muxed_addr_data_in,
		.muxed_addr_data_out, .muxed_addr_data_oe, .command_byte_enable_n_out,
		.command_byte_enable_n_oe, .cycle_frame_n_out, .cycle_frame_n_oe,
		.initiator_ready_n_out, .initiator_ready_oe, .target_ready_n,
		.addr_data_strobe_0_in, .addr_data_strobe_0_out, .addr_data_strobe_0_oe,
		.addr_data_strobe_1_in, .addr_data_strobe_1_out, .addr_data_strobe_1_oe,
		.req_valid, .req_ready, .req_addr, .req_cmd, .pci_start_req, .pci_start_ack,
		.rd_space_lp, .rd_valid, .rd_data, .rd_high_prio, .wr_valid, .wr_ready,
		.wr_data, .wr_byte_en_n, .wr_last, .wr_high_prio
	);

	ams_arbiter_model i_ams_arbiter_model (
		.clk_sys, .bus_grant_n, .arbiter_status_code, .target_ready_n, .ad_drv,
		.read_buffer_full_n, .pipelined_request_n, .pipelined_request_oe,
		.initiator_ready_n(initiator_ready_n_out), .ad_dev(muxed_addr_data_out),
		.cbe_dev(command_byte_enable_n_out)
	);

	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	always @(posedge clk_sys) if (rd_valid === 1'b1) rd_log.push_back({rd_high_prio, rd_data});

	// ========
	// Helpers
	task chk(input logic ok, input string m);
		n_compared++;
		// Unknown counts as a mismatch
		if (ok !== 1'b1) begin
			fails++;
			$display("wrong value at %0t ns: %s", $time, m);
		end
	endtask : chk

	function automatic logic quiet();
		return req_ready === 1'b0 && pci_start_ack === 1'b0 && wr_ready === 1'b0
			&& initiator_ready_oe === 1'b0 && pipelined_request_oe === 1'b0
			&& cycle_frame_n_oe === 1'b0;
	endfunction : quiet

	// Holds the request over the edge that takes it
	task await_rdy(input int w);
		int k;
		k = 0;
		#1;
		while ((w == 0 ? req_ready : w == 1 ? wr_ready : pci_start_ack) !== 1'b1) begin
			@(negedge clk_sys);
			#1;
			k++;
			if (k > 20) begin
				chk(1'b0, "no handshake");
				return;
			end
		end
		@(posedge clk_sys);
	endtask : await_rdy

	task push_req(input logic [31:0] a, input logic [3:0] c);
		@(negedge clk_sys);
		req_valid = 1'b1;
		req_addr = a;
		req_cmd = c;
		await_rdy(0);
	endtask : push_req

	task push_wr(input logic [31:0] d, input logic [3:0] b, input logic l);
		@(negedge clk_sys);
		wr_valid = 1'b1;
		wr_data = d;
		wr_byte_en_n = b;
		wr_last = l;
		await_rdy(1);
	endtask : push_wr

	// ========
	// Scenarios
	task t_reset();
		@(negedge clk_sys);
		chk(pipelined_request_oe === 1'b0 && pipelined_request_n === 1'b1, "pipe at reset");
		chk(addr_data_strobe_0_oe === 1'b0 && addr_data_strobe_1_oe === 1'b0, "strobe");
		chk(addr_data_strobe_0_out === 1'b0 && addr_data_strobe_1_out === 1'b0, "strobe out");
		chk(command_byte_enable_n_out === 4'hf && command_byte_enable_n_oe === 1'b0, "cbe");
		chk(muxed_addr_data_out === 32'h0000_0000 && muxed_addr_data_oe === 1'b0, "ad");
		chk(cycle_frame_n_out === 1'b1 && initiator_ready_n_out === 1'b1, "ctl");
		chk(rd_valid === 1'b0 && initiator_ready_oe === 1'b0, "rd at reset");
		$display("test reset done");
	endtask : t_reset

	task t_queue();
		i_ams_arbiter_model.grant(3'h7);
		for (int i = 0; i < 3; i++) push_req(32'h1000_0000 + 32'(i), 4'(i));
		i_ams_arbiter_model.grant(3'h5);
		req_valid = 1'b0;
		chk(pipelined_request_n === 1'b0 && muxed_addr_data_out === 32'h1000_0002, "last");
		chk(muxed_addr_data_oe === 1'b1 && command_byte_enable_n_oe === 1'b1, "ad undriven");
		@(negedge clk_sys);
		chk(pipelined_request_n === 1'b1 && pipelined_request_oe === 1'b1, "not parked");
		chk(muxed_addr_data_oe === 1'b0 && command_byte_enable_n_oe === 1'b0, "ad held");
		@(negedge clk_sys);
		chk(pipelined_request_oe === 1'b0, "pipe not released");
		req_valid = 1'b1;
		repeat (4) begin
			@(negedge clk_sys);
			#1;
			chk(quiet(), "queued without start");
		end
		i_ams_arbiter_model.drop_grant();
		req_valid = 1'b0;
		i_ams_arbiter_model.grant(3'h7);
		push_req(32'h1000_0003, 4'h3);
		i_ams_arbiter_model.drop_grant();
		req_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(i_ams_arbiter_model.queued.size() == 4, "queue count");
		for (int i = 0; i < 4; i++)
			chk(i_ams_arbiter_model.queued[i] === {4'(i), 32'h1000_0000 + 32'(i)}, "req");
		$display("test queue done");
	endtask : t_queue

	task t_ignore();
		@(negedge clk_sys);
		req_valid = 1'b1;
		pci_start_req = 1'b1;
		wr_valid = 1'b1;
		repeat (8) begin
			@(negedge clk_sys);
			#1;
			chk(quiet(), "code used without grant");
		end
		for (int c = 4; c < 7; c++) begin
			i_ams_arbiter_model.grant(3'(c));
			#1;
			chk(quiet(), "reserved code acted on");
		end
		i_ams_arbiter_model.drop_grant();
		req_valid = 1'b0;
		pci_start_req = 1'b0;
		wr_valid = 1'b0;
		$display("test ignore done");
	endtask : t_ignore

	task t_frame();
		i_ams_arbiter_model.grant(3'h7);
		pci_start_req = 1'b1;
		await_rdy(2);
		i_ams_arbiter_model.drop_grant();
		pci_start_req = 1'b0;
		chk(cycle_frame_n_out === 1'b0 && cycle_frame_n_oe === 1'b1, "no frame");
		@(negedge clk_sys);
		chk(cycle_frame_n_out === 1'b1 && cycle_frame_n_oe === 1'b1, "frame park");
		@(negedge clk_sys);
		chk(cycle_frame_n_oe === 1'b0, "frame held");
		$display("test frame done");
	endtask : t_frame

	task t_read(input logic [2:0] c, input int n, input int exp_n);
		rd_log.delete();
		fork
			i_ams_arbiter_model.read_back(c, n, 32'hc0de_0000);
			begin
				repeat (2) @(negedge clk_sys);
				if (exp_n > 0)
					chk(initiator_ready_n_out === 1'b0 && initiator_ready_oe === 1'b1, "wait");
			end
		join
		repeat (3) @(negedge clk_sys);
		chk(rd_log.size() == exp_n && initiator_ready_oe === 1'b0, "read count");
		for (int i = 0; i < exp_n; i++)
			chk(rd_log[i] === {c == 3'h1, 32'hc0de_0000 + 32'(i)}, "read data");
		$display("test read done");
	endtask : t_read

	task t_rbf();
		rd_space_lp = 1'b0;
		repeat (2) @(negedge clk_sys);
		chk(read_buffer_full_n === 1'b0, "buffer full not shown");
		t_read(3'h0, 2, 0);
		t_read(3'h1, 2, 2);
		rd_space_lp = 1'b1;
		repeat (2) @(negedge clk_sys);
		chk(read_buffer_full_n === 1'b1, "buffer space not shown");
		$display("test rbf done");
	endtask : t_rbf

	task t_write(input logic [2:0] c);
		i_ams_arbiter_model.written.delete();
		fork
			i_ams_arbiter_model.write_take(c, 3);
			for (int i = 0; i < 3; i++) push_wr(32'hbeef_0000 + 32'(i), 4'(i), i == 2);
			begin
				repeat (3) @(negedge clk_sys);
				chk(wr_high_prio === (c == 3'h3), "write priority");
			end
		join
		wr_valid = 1'b0;
		repeat (3) @(negedge clk_sys);
		chk(i_ams_arbiter_model.written.size() == 3, "write beats");
		for (int i = 0; i < 3; i++)
			chk(i_ams_arbiter_model.written[i] === {4'(i), 32'hbeef_0000 + 32'(i)}, "wr");
		$display("test write done");
	endtask : t_write

	task results();
		$display("compared %0d mismatched %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : results

	initial begin
		repeat (5) @(negedge clk_sys);
		reset = 1'b0;
		t_reset();
		t_queue();
		t_ignore();
		t_frame();
		t_read(3'h0, 3, 3);
		t_read(3'h1, 1, 1);
		t_rbf();
		t_write(3'h2);
		t_write(3'h3);
		results();
	end

	// Run needs about 100 cycles
	initial begin
		#100000;
		chk(1'b0, "watchdog expired");
		results();
	end
endmodule : ams_sideband_ctrl_bench

`default_nettype wire
